// ---- verilog/logic_eval_regs.svh ----
// Register offsets, field positions and timing counts of the evaluator
`ifndef LOGIC_EVAL_REGS_SVH
`define LOGIC_EVAL_REGS_SVH
`define ADDR_W 13
`define ENTRY_COUNT 512
`define ENTRY_IDX_W 9
`define ENTRY_LAST 9'h1ff
`define CTRL_OFS 13'h0800
`define STATUS_OFS 13'h0804
`define PASS_OFS 13'h0808
`define VOUT_LO_OFS 13'h0810
`define VOUT_HI_OFS 13'h0814
`define TOUT_OFS 13'h0818
`define CTRL_RUN_BIT 0
`define ST_ERR_BIT 0
`define ST_RUN_BIT 1
`define END_ENTRY 16'h0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define REF_CLK_HZ 20000000
`define TICK_MS_TIME 1
`define MS_CYCLES (`REF_CLK_HZ / 1000 * `TICK_MS_TIME)
`define MS_PER_S 1000
`define S_PER_MIN 60
`endif

// ---- verilog/logic_eval_pkg.sv ----
// Types shared by the evaluator files
package logic_eval_pkg;
   typedef enum logic [3:0] {
      K_END = 4'h0, K_CONST = 4'h1, K_VOUT = 4'h2, K_VIN = 4'h3,
      K_CONTACT = 4'h4, K_ELEM_OP = 4'h5, K_ELEM_PKP = 4'h6,
      K_OR = 4'h7, K_AND = 4'h8, K_NOR = 4'h9, K_NAND = 4'ha,
      K_XOR = 4'hb, K_NOT = 4'hc, K_LATCH = 4'hd, K_TIMER = 4'he,
      K_ASSIGN = 4'hf
   } kind_t;
   typedef struct packed {
      logic [3:0] rsv;
      kind_t kind;
      logic [7:0] arg;
   } entry_t;
   typedef enum logic [3:0] {
      SEL_NONE = 4'h0, SEL_ENTRY = 4'h1, SEL_CTRL = 4'h2,
      SEL_STATUS = 4'h3, SEL_PASS = 4'h4, SEL_VLO = 4'h5,
      SEL_VHI = 4'h6, SEL_TOUT = 4'h7, SEL_TDLY = 4'h8, SEL_TTYPE = 4'h9
   } reg_sel_t;
   typedef enum logic [1:0] {
      U_MS = 2'h0, U_S = 2'h1, U_MIN = 2'h2, U_MIN2 = 2'h3
   } tmr_unit_t;
   typedef enum logic {ST_IDLE = 1'b0, ST_EVAL = 1'b1} eval_state_t;
   typedef struct packed {
      logic [15:0] enable;
      logic [15:0] op;
      logic [15:0] pkp;
   } elem_in_t;
endpackage

// ---- verilog/logic_tick.sv ----
// Divider that makes millisecond, second and minute enable pulses
`include "logic_eval_regs.svh"
module logic_tick #(
   parameter int MS_CYCLES = `MS_CYCLES,
   parameter int MS_PER_S = `MS_PER_S,
   parameter int S_PER_MIN = `S_PER_MIN
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   output logic [2:0] o_tick
);
   typedef struct packed {
      logic [31:0] cms;
      logic [15:0] cs;
      logic [7:0] cm;
      logic [2:0] tick;
   } tick_st_t;
   tick_st_t st_reg, st_next;
   always_comb begin
      st_next = st_reg;
      st_next.tick = 3'h0;
      if (st_reg.cms == 32'(MS_CYCLES - 1)) begin
         st_next.cms = 32'h0000_0000;
         st_next.tick[0] = 1'b1;
         if (st_reg.cs == 16'(MS_PER_S - 1)) begin
            st_next.cs = 16'h0000;
            st_next.tick[1] = 1'b1;
            if (st_reg.cm == 8'(S_PER_MIN - 1)) begin
               st_next.cm = 8'h00;
               st_next.tick[2] = 1'b1;
            end else begin
               st_next.cm = st_reg.cm + 8'h01;
            end
         end else begin
            st_next.cs = st_reg.cs + 16'h0001;
         end
      end else begin
         st_next.cms = st_reg.cms + 32'h0000_0001;
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) st_reg <= '0;
      else st_reg <= st_next;
   end
   assign o_tick = st_reg.tick;
endmodule

// ---- verilog/logic_timer.sv ----
// One pickup/dropout delay timer
module logic_timer (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_in,
   input wire logic i_tick,
   input wire logic [15:0] i_pickup,
   input wire logic [15:0] i_dropout,
   output logic o_q
);
   typedef struct packed {
      logic q;
      logic [15:0] cnt;
   } tmr_st_t;
   tmr_st_t st_reg, st_next;
   logic [15:0] dly;
   always_comb begin
      st_next = st_reg;
      dly = st_reg.q ? i_dropout : i_pickup;
      // Any return of the input restarts the delay from zero
      if (i_in == st_reg.q) begin
         st_next.cnt = 16'h0000;
      end else if (dly == 16'h0000) begin
         st_next.q = i_in;
      end else if (i_tick) begin
         if ({1'b0, st_reg.cnt} + 17'h0_0001 >= {1'b0, dly}) begin
            st_next.q = i_in;
            st_next.cnt = 16'h0000;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) st_reg <= '0;
      else st_reg <= st_next;
   end
   assign o_q = st_reg.q;
endmodule

// ---- verilog/logic_eval.sv ----
// Programmable postfix logic evaluator with timers and AXI4-Lite registers
`include "logic_eval_regs.svh"

// Operation
// - Gate of N inputs combines N preceding results (code caps N at 16)
// - Gates carry explicit input count
// - Inverter complements the single preceding result
// - Latch: preceding is reset, before that set
// - Unassigned virtual output reads its latest state
// - At least four passes per power cycle
// - Pass stops at first end marker
// - Constant true and false operands exist
// - 512 entries, all end markers after reset
// - Disabled element flag reads false
// - Thirty-two identical timers usable as operators
// - Timer type selects delay unit
// - Pickup after input true for delay
// - Dropout after input false for delay
// - Timer driven by preceding result, pushes output
// - Assignment stores result, ends equation
// - Latch is reset dominant
// - Duplicate timer or assignment flags syntax error
module logic_eval #(
   parameter int MS_CYCLES = `MS_CYCLES,
   parameter int STACK_D = 32,
   parameter int LATCHES = 16
) (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic [`ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [`ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic [63:0] i_virtual_inputs,
   input wire logic [63:0] i_contact_pins,
   input logic_eval_pkg::elem_in_t i_elements,
   output logic [63:0] o_virtual_outputs,
   output logic [31:0] o_timer_outputs,
   output logic o_syntax_error,
   output logic o_pass_done
);
   import logic_eval_pkg::*;

   // ***********************************************************
   // State
   // ***********************************************************
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic bvalid;
      logic rvalid;
      logic [`ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [1:0] bresp;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic run;
      logic err;
      logic pass_done;
      logic [31:0] pass_cnt;
      eval_state_t state;
      logic [`ENTRY_IDX_W-1:0] pc;
      logic [STACK_D-1:0] stack;
      logic [63:0] vout;
      logic [63:0] used_v;
      logic [31:0] used_t;
      logic [31:0] tmr_in;
      logic [LATCHES-1:0] latch;
      logic [31:0][31:0] tdly;
      logic [31:0][1:0] ttype;
      logic [63:0] s1;
      logic [63:0] s2;
      logic [63:0] s3;
      logic [63:0] cfilt;
      logic [`ENTRY_COUNT-1:0] evalid;
   } state_t;

   state_t st_reg, st_next;
   logic [15:0] mem [`ENTRY_COUNT];
   logic mem_we;
   logic [`ENTRY_IDX_W-1:0] mem_wa;
   logic [15:0] mem_wd;
   logic [2:0] tick;
   logic [31:0] tq;
   logic [31:0] tsel;

   // ***********************************************************
   // Helpers
   // ***********************************************************
   function automatic reg_sel_t decode(input logic [`ADDR_W-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if (a[12:11] == 2'h0) begin
         s = SEL_ENTRY;
      end else if (a[12] && a[11:8] == 4'h0) begin
         s = a[2] ? SEL_TTYPE : SEL_TDLY;
      end else begin
         case ({a[12:2], 2'h0})
            `CTRL_OFS: s = SEL_CTRL;
            `STATUS_OFS: s = SEL_STATUS;
            `PASS_OFS: s = SEL_PASS;
            `VOUT_LO_OFS: s = SEL_VLO;
            `VOUT_HI_OFS: s = SEL_VHI;
            `TOUT_OFS: s = SEL_TOUT;
            default: s = SEL_NONE;
         endcase
      end
      return s;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] d, input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) m[8*b +: 8] = d[8*b +: 8];
      end
      return m;
   endfunction

   // Drops n results and pushes one; missing operands read as zero
   function automatic logic [STACK_D-1:0] pop_push(
         input logic [STACK_D-1:0] s, input logic [4:0] n, input logic b);
      logic [STACK_D-1:0] t;
      t = s >> n;
      return {t[STACK_D-2:0], b};
   endfunction

   function automatic logic [STACK_D-1:0] gate_mask(input logic [4:0] n);
      logic [STACK_D-1:0] m;
      m = '0;
      for (int i = 0; i < 16; i++) begin
         m[i] = (5'(i) < n);
      end
      return m;
   endfunction

   // ***********************************************************
   // Timers
   // ***********************************************************
   logic_tick #(
      .MS_CYCLES(MS_CYCLES),
      .MS_PER_S(`MS_PER_S),
      .S_PER_MIN(`S_PER_MIN)
   ) u_tick (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .o_tick(tick)
   );

   for (genvar g = 0; g < 32; g++) begin : g_tmr
      always_comb begin
         case (tmr_unit_t'(st_reg.ttype[g]))
            U_MS: tsel[g] = tick[0];
            U_S: tsel[g] = tick[1];
            default: tsel[g] = tick[2];
         endcase
      end
      logic_timer u_timer (
         .i_ref_clk(i_ref_clk),
         .i_rstn(i_rstn),
         .i_in(st_reg.tmr_in[g]),
         .i_tick(tsel[g]),
         .i_pickup(st_reg.tdly[g][15:0]),
         .i_dropout(st_reg.tdly[g][31:16]),
         .o_q(tq[g])
      );
   end

   // ***********************************************************
   // Next state
   // ***********************************************************
   entry_t ent;
   reg_sel_t wsel;
   reg_sel_t rsel;
   logic [4:0] gn;
   logic [STACK_D-1:0] gm;
   logic res;
   logic tin;
   logic pass_end;
   logic [15:0] tp;
   logic [15:0] td;

   always_comb begin
      st_next = st_reg;
      mem_we = 1'b0;
      mem_wa = st_reg.awaddr[10:2];
      mem_wd = mem[st_reg.awaddr[10:2]];
      st_next.pass_done = 1'b0;
      // Contacts: change counts once the second and third stages agree
      st_next.s1 = i_contact_pins;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.cfilt = (st_reg.s2 & st_reg.s3) |
         (st_reg.cfilt & (st_reg.s2 | st_reg.s3));

      // Register bus, write side
      if (i_awvalid && !st_reg.aw_got) begin
         st_next.aw_got = 1'b1;
         st_next.awaddr = i_awaddr;
      end
      if (i_wvalid && !st_reg.w_got) begin
         st_next.w_got = 1'b1;
         st_next.wdata = i_wdata;
         st_next.wstrb = i_wstrb;
      end
      if (st_reg.bvalid && i_bready) st_next.bvalid = 1'b0;
      wsel = decode(st_reg.awaddr);
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
         st_next.aw_got = 1'b0;
         st_next.w_got = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = `RESP_OKAY;
         case (wsel)
            SEL_ENTRY: begin
               mem_we = 1'b1;
               mem_wd = 16'(merge({16'h0000, mem[mem_wa]}, st_reg.wdata,
                  st_reg.wstrb));
               if (!st_reg.evalid[mem_wa]) begin
                  // Untouched entries hold the end marker
                  mem_wd = 16'(merge({16'h0000, `END_ENTRY}, st_reg.wdata,
                     st_reg.wstrb));
               end
               st_next.evalid[mem_wa] = 1'b1;
            end
            SEL_CTRL: begin
               if (st_reg.wstrb[0]) begin
                  st_next.run = st_reg.wdata[`CTRL_RUN_BIT];
               end
            end
            SEL_STATUS: begin
               if (st_reg.wstrb[0] && st_reg.wdata[`ST_ERR_BIT]) begin
                  st_next.err = 1'b0;
               end
            end
            SEL_TDLY: begin
               st_next.tdly[st_reg.awaddr[7:3]] = merge(
                  st_reg.tdly[st_reg.awaddr[7:3]], st_reg.wdata,
                  st_reg.wstrb);
            end
            SEL_TTYPE: begin
               if (st_reg.wstrb[0]) begin
                  st_next.ttype[st_reg.awaddr[7:3]] = st_reg.wdata[1:0];
               end
            end
            SEL_PASS, SEL_VLO, SEL_VHI, SEL_TOUT: begin
               st_next.bresp = `RESP_OKAY;
            end
            default: st_next.bresp = `RESP_SLVERR;
         endcase
      end

      // Register bus, read side
      if (st_reg.rvalid && i_rready) st_next.rvalid = 1'b0;
      rsel = decode(i_araddr);
      if (i_arvalid && !st_reg.rvalid) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = `RESP_OKAY;
         st_next.rdata = 32'h0000_0000;
         case (rsel)
            SEL_ENTRY: begin
               if (st_reg.evalid[i_araddr[10:2]]) begin
                  st_next.rdata = {16'h0000, mem[i_araddr[10:2]]};
               end
            end
            SEL_CTRL: st_next.rdata[`CTRL_RUN_BIT] = st_reg.run;
            SEL_STATUS: begin
               st_next.rdata[`ST_ERR_BIT] = st_reg.err;
               st_next.rdata[`ST_RUN_BIT] = (st_reg.state == ST_EVAL);
            end
            SEL_PASS: st_next.rdata = st_reg.pass_cnt;
            SEL_VLO: st_next.rdata = st_reg.vout[31:0];
            SEL_VHI: st_next.rdata = st_reg.vout[63:32];
            SEL_TOUT: st_next.rdata = tq;
            SEL_TDLY: st_next.rdata = st_reg.tdly[i_araddr[7:3]];
            SEL_TTYPE: st_next.rdata[1:0] = st_reg.ttype[i_araddr[7:3]];
            default: st_next.rresp = `RESP_SLVERR;
         endcase
      end

      // Evaluator: one entry per clock
      ent = st_reg.evalid[st_reg.pc] ? entry_t'(mem[st_reg.pc]) :
         entry_t'(`END_ENTRY);
      gn = (ent.arg[4:0] > 5'h10) ? 5'h10 : ent.arg[4:0];
      gm = gate_mask(gn);
      tp = st_reg.tdly[ent.arg[4:0]][15:0];
      td = st_reg.tdly[ent.arg[4:0]][31:16];
      tin = st_reg.stack[0];
      res = 1'b0;
      pass_end = 1'b0;
      case (st_reg.state)
         ST_IDLE: begin
            if (st_reg.run) st_next.state = ST_EVAL;
         end
         ST_EVAL: begin
            case (ent.kind)
               K_END: pass_end = 1'b1;
               K_CONST: begin
                  st_next.stack = pop_push(st_reg.stack, 5'h00,
                     ent.arg[0]);
               end
               K_VOUT: begin
                  st_next.stack = pop_push(st_reg.stack, 5'h00,
                     st_reg.vout[ent.arg[5:0]]);
               end
               K_VIN: begin
                  st_next.stack = pop_push(st_reg.stack, 5'h00,
                     i_virtual_inputs[ent.arg[5:0]]);
               end
               K_CONTACT: begin
                  st_next.stack = pop_push(st_reg.stack, 5'h00,
                     st_reg.cfilt[ent.arg[5:0]]);
               end
               K_ELEM_OP, K_ELEM_PKP: begin
                  res = i_elements.enable[ent.arg[3:0]] &
                     ((ent.kind == K_ELEM_OP) ?
                     i_elements.op[ent.arg[3:0]] :
                     i_elements.pkp[ent.arg[3:0]]);
                  st_next.stack = pop_push(st_reg.stack, 5'h00, res);
               end
               K_OR, K_NOR: begin
                  res = |(st_reg.stack & gm);
                  if (ent.kind == K_NOR) res = ~res;
                  st_next.stack = pop_push(st_reg.stack, gn, res);
               end
               K_AND, K_NAND: begin
                  res = &(st_reg.stack | ~gm);
                  if (ent.kind == K_NAND) res = ~res;
                  st_next.stack = pop_push(st_reg.stack, gn, res);
               end
               K_XOR: begin
                  res = ^(st_reg.stack & gm);
                  st_next.stack = pop_push(st_reg.stack, gn, res);
               end
               K_NOT: begin
                  st_next.stack = pop_push(st_reg.stack, 5'h01,
                     ~st_reg.stack[0]);
               end
               K_LATCH: begin
                  // Set is second from top, reset is on top
                  res = ~st_reg.stack[0] & (st_reg.stack[1] |
                     st_reg.latch[ent.arg[3:0]]);
                  st_next.latch[ent.arg[3:0]] = res;
                  st_next.stack = pop_push(st_reg.stack, 5'h02, res);
               end
               K_TIMER: begin
                  st_next.tmr_in[ent.arg[4:0]] = tin;
                  // Zero delays bypass the timer's one-cycle lag
                  if (tin) res = (tp == 16'h0000) | tq[ent.arg[4:0]];
                  else res = (td != 16'h0000) & tq[ent.arg[4:0]];
                  st_next.stack = pop_push(st_reg.stack, 5'h01, res);
                  if (st_reg.used_t[ent.arg[4:0]]) st_next.err = 1'b1;
                  st_next.used_t[ent.arg[4:0]] = 1'b1;
               end
               K_ASSIGN: begin
                  st_next.vout[ent.arg[5:0]] = st_reg.stack[0];
                  st_next.stack = '0;
                  if (st_reg.used_v[ent.arg[5:0]]) st_next.err = 1'b1;
                  st_next.used_v[ent.arg[5:0]] = 1'b1;
               end
               default: pass_end = 1'b1;
            endcase
            st_next.pc = st_reg.pc + 9'h001;
            if (st_reg.pc == `ENTRY_LAST) pass_end = 1'b1;
            if (pass_end) begin
               // Passes run back to back, at least 39 per millisecond
               st_next.pc = '0;
               st_next.stack = '0;
               st_next.used_t = 32'h0000_0000;
               st_next.used_v = '0;
               st_next.pass_done = 1'b1;
               st_next.pass_cnt = st_reg.pass_cnt + 32'h0000_0001;
               if (!st_reg.run) st_next.state = ST_IDLE;
            end
         end
         default: st_next.state = ST_IDLE;
      endcase
   end

   // ***********************************************************
   // Registers
   // ***********************************************************
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) st_reg <= '0;
      else st_reg <= st_next;
   end

   // Entry store has no reset; the valid bits mask its content
   always_ff @(posedge i_ref_clk) begin
      if (mem_we) mem[mem_wa] <= mem_wd;
   end

   assign o_awready = ~st_reg.aw_got;
   assign o_wready = ~st_reg.w_got;
   assign o_bvalid = st_reg.bvalid;
   assign o_bresp = st_reg.bresp;
   assign o_arready = ~st_reg.rvalid;
   assign o_rvalid = st_reg.rvalid;
   assign o_rdata = st_reg.rdata;
   assign o_rresp = st_reg.rresp;
   assign o_virtual_outputs = st_reg.vout;
   assign o_timer_outputs = tq;
   assign o_syntax_error = st_reg.err;
   assign o_pass_done = st_reg.pass_done;
endmodule

// ---- test/logic_eval_assertions.sv ----
// Bus handshake and status checks bound to the logic evaluator
`include "logic_eval_regs.svh"
module logic_eval_assertions (
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic o_syntax_error
);
   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   a_bresp_held:
      assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
      else $error("write response dropped early");
   a_rdata_held:
      assert property (o_rvalid && !i_rready |=>
         o_rvalid && $stable(o_rdata) && $stable(o_rresp))
      else $error("read data dropped early");
   a_write_answer:
      assert property (i_awvalid && o_awready && i_wvalid && o_wready
         |-> ##[1:2] o_bvalid)
      else $error("write response late");
   a_read_answer:
      assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read data late");
   a_ar_blocked:
      assert property (o_rvalid |-> !o_arready)
      else $error("read accepted while data pending");
   a_aw_blocked:
      assert property (i_awvalid && o_awready |=> !o_awready)
      else $error("second write address accepted");
   a_slverr_zero:
      assert property (o_rvalid && o_rresp == `RESP_SLVERR |-> o_rdata == '0)
      else $error("error read returns data");
   a_error_sticky:
      assert property (o_syntax_error && o_awready |=> o_syntax_error)
      else $error("syntax flag cleared without a write");
endmodule
bind logic_eval logic_eval_assertions u_chk (.*);

// ---- test/logic_eval_bench.sv ----
// Self-checking bench of the logic evaluator
`include "logic_eval_regs.svh"
module logic_eval_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import logic_eval_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic ref_clk = 1'b0, rst_n = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [12:0] awaddr = 13'h0000, araddr = 13'h0000;
   logic [31:0] wdata = 32'h0000_0000;
   logic [63:0] vin = 64'h0, pins = 64'h0;
   elem_in_t elem = '0;
   logic awready, wready, bvalid, arready, rvalid, syn_err, pass_done;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, tout, d;
   logic [63:0] vout;
   int errors = 0, checks = 0;
   // Equations: gate, latch, constants, feedback copy, timer, tail past end
   logic [15:0] prog [22] = '{16'h0501, 16'h0400, 16'h0c00, 16'h0802,
      16'h0f03, 16'h0300, 16'h0301, 16'h0d00, 16'h0f04, 16'h0101,
      16'h0100, 16'h0100, 16'h0703, 16'h0f05, 16'h0206, 16'h0f09,
      16'h0302, 16'h0e1f, 16'h0f06, 16'h0000, 16'h0101, 16'h0f07};
   always #25 ref_clk = ~ref_clk;
   // Short millisecond so timer delays stay within a few passes
   logic_eval #(.MS_CYCLES(20)) dut (
      .i_ref_clk(ref_clk), .i_rstn(rst_n), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
      .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .i_virtual_inputs(vin), .i_contact_pins(pins),
      .i_elements(elem), .o_virtual_outputs(vout),
      .o_timer_outputs(tout), .o_syntax_error(syn_err),
      .o_pass_done(pass_done));
   // ****************************************
   // Helpers
   // ****************************************
   task chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t mismatch got %0h exp %0h", $time, got, exp);
      end
   endtask
   task wr(input logic [12:0] a, input logic [31:0] v);
      logic pa, pw, pb, ok_a, ok_w, ok_b;
      logic [1:0] resp;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      // Answers are sampled mid-cycle, clear of the edge that launches them
      while (pa || pw || pb) begin
         @(negedge ref_clk);
         ok_a = awready;
         ok_w = wready;
         ok_b = bvalid;
         resp = bresp;
         @(posedge ref_clk);
         if (pa && ok_a) begin
            awvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pw && ok_w) begin
            wvalid <= 1'b0;
            pw = 1'b0;
         end
         if (pb && ok_b) begin
            bready <= 1'b0;
            pb = 1'b0;
            r = resp;
         end
      end
   endtask
   task rd(input logic [12:0] a);
      logic pa, pr, ok_a, ok_r;
      logic [1:0] resp;
      logic [31:0] data;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      pa = 1'b1;
      pr = 1'b1;
      while (pa || pr) begin
         @(negedge ref_clk);
         ok_a = arready;
         ok_r = rvalid;
         data = rdata;
         resp = rresp;
         @(posedge ref_clk);
         if (pa && ok_a) begin
            arvalid <= 1'b0;
            pa = 1'b0;
         end
         if (pr && ok_r) begin
            rready <= 1'b0;
            pr = 1'b0;
            d = data;
            r = resp;
         end
      end
   endtask
   task passes(input int n);
      // The pulse stands for one cycle; look at it away from its edge
      repeat (n) @(negedge ref_clk iff pass_done);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      rd(13'h0000);
      chk(d, 0);
      rd(13'h07fc);
      chk(d, 0);
      rd(13'h0c00);
      chk(r, `RESP_SLVERR);
      wr(13'h0c00, 32'h0000_0001);
      chk(r, `RESP_SLVERR);
   endtask
   task t_load;
      foreach (prog[i]) begin
         wr(13'(4 * i), {16'h0000, prog[i]});
         chk(r, `RESP_OKAY);
      end
      wr(13'h10f8, 32'h0000_0005);
      wr(13'h10fc, 32'h0000_0000);
      wr(`CTRL_OFS, 32'h0000_0001);
      rd(13'h000c);
      chk(d, 32'h0000_0802);
   endtask
   task t_gates;
      @(posedge ref_clk);
      elem.enable[1] <= 1'b1;
      elem.op[1] <= 1'b1;
      passes(3);
      chk(vout[3], 1);
      chk(vout[5], 1);
      chk(vout[7], 0);
      @(posedge ref_clk);
      elem.enable[1] <= 1'b0;
      passes(3);
      chk(vout[3], 0);
      @(posedge ref_clk);
      elem.enable[1] <= 1'b1;
      pins[0] <= 1'b1;
      passes(3);
      chk(vout[3], 0);
   endtask
   task t_latch;
      // Each step is set, reset and the expected latch output
      logic [2:0] seq [4] = '{3'h5, 3'h1, 3'h6, 3'h0};
      foreach (seq[i]) begin
         @(posedge ref_clk);
         vin[1:0] <= {seq[i][1], seq[i][2]};
         passes(2);
         chk(vout[4], seq[i][0]);
      end
   endtask
   task t_timer;
      @(posedge ref_clk);
      vin[2] <= 1'b1;
      passes(2);
      chk(tout[31], 0);
      passes(7);
      chk(tout[31], 1);
      passes(1);
      chk(vout[6], 1);
      passes(1);
      chk(vout[9], 1);
      @(posedge ref_clk);
      vin[2] <= 1'b0;
      passes(2);
      chk(tout[31], 0);
      wr(13'h10fc, 32'h0000_0001);
      wr(13'h10f8, 32'h0000_0002);
      @(posedge ref_clk);
      vin[2] <= 1'b1;
      passes(9);
      chk(tout[31], 0);
   endtask
   task t_dup;
      // Second assignment of the same output replaces the end marker
      wr(13'h004c, 32'h0000_0f05);
      passes(2);
      chk(syn_err, 1);
      rd(`STATUS_OFS);
      chk(d[0], 1);
   endtask
   task results;
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset;
      t_load;
      t_gates;
      t_latch;
      t_timer;
      t_dup;
      results;
   end
   // Whole run needs about a thousand cycles; cut off at twenty thousand
   initial begin
      #1_000_000;
      errors++;
      results;
   end
endmodule
